// File: acx_map.svh
// register offsets, field positions, reset values and ascii codes
// for the audio crosspoint; included by the crosspoint, its checker and the bench
`ifndef ACX_MAP_SVH
`define ACX_MAP_SVH

`define ACX_OFS_SWITCH     8'h00
`define ACX_OFS_ROUTES     8'h04
`define ACX_OFS_AUTO       8'h08
`define ACX_OFS_RANK       8'h0C
`define ACX_OFS_HOLD       8'h10
`define ACX_OFS_IRQ_STAT   8'h14
`define ACX_OFS_IRQ_MASK   8'h18
`define ACX_OFS_AUTO_TXT0  8'h1C
`define ACX_OFS_AUTO_TXT1  8'h20
`define ACX_OFS_CODE_BASE  8'h40
`define ACX_OFS_CODE_LAST  8'h64

`define ACX_SW_IN_BIT      0
`define ACX_SW_OUT_LSB     1
`define ACX_SW_ALL_BIT     8
`define ACX_AUTO_SEL_LSB   16
`define ACX_HOLD_LOCK_LSB  8

`define ACX_RST_AUTO       12'h0000
`define ACX_RST_RANK       6'b10_1010
`define ACX_RST_HOLD       5'b0_0000

`define ACX_IRQ_REFUSED    3
`define ACX_IRQ_PORTCHG    4

`define ACX_CH_T           8'h54
`define ACX_CH_L           8'h4C
`define ACX_CH_M           8'h4D
`define ACX_CH_U           8'h55
`define ACX_CH_E           8'h45
`define ACX_CH_D           8'h44
`define ACX_CH_F           8'h46
`define ACX_CH_P           8'h50
`define ACX_CH_S           8'h53
`define ACX_CH_0           8'h30
`define ACX_CH_A_LESS10    8'h37

`endif

// File: acx_pkg.sv
// types shared by the audio crosspoint
// assumes nothing of its surroundings
`default_nettype none

package acx_pkg;

   typedef enum logic [1:0]
   {
      ACX_MODE_FIRST    = 2'h0,
      ACX_MODE_PRIORITY = 2'h1,
      ACX_MODE_LAST     = 2'h2,
      ACX_MODE_STATIC   = 2'h3
   } acx_mode_type;

endpackage : acx_pkg

`default_nettype wire

// File: acx_crosspoint.sv
// audio crosspoint: two inputs, three outputs, manual and automatic
// routing, per-port mute/lock state and status codes, apb registers
// assumes apb master on clk_sys; port sense pins asynchronous;
// audio samples arrive synchronous to clk_sys
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
`include "acx_map.svh"

// How it works
// - each port reads back as five ascii characters: letter plus four hex
// - letter T, L, M or U gives mute and lock together
// - low status byte: bits 3-2 signal presence, 1-0 connection; rest zero
// - idle (absent) port codes are T0008, T000A or T000B
// - output codes are listed per output, in output order
// - route table gives each output's input; inputs may be shared
// - single route changes only the named output
// - route-to-every-output sets all three outputs to one input
// - auto pick code: E or D, then the mode letter
// - first mode takes the first input that becomes active
// - priority mode takes the best ranked active input
// - last mode takes the most recently attached input
// - static mode follows the video choice when video has audio
// - auto pick set updates only the outputs it names
// - rank list gives a rank per input for each output
// - a lower rank number wins
// - equal ranks: lower input number wins
module acx_crosspoint
#(
   parameter int AUD_W = 24
)
(
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         resetn,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output var  logic [31:0]                  prdata,
   output var  logic                         pready,
   output var  logic                         pslverr,
   // port sense pins, order in1, in2, out1, out2, out3
   input  wire logic [4:0]                   port_present,
   input  wire logic [4:0]                   port_link_known,
   input  wire logic [4:0]                   port_linked,
   // video selection per output, for static mode
   input  wire logic [2:0]                   video_sel,
   input  wire logic [2:0]                   video_has_audio,
   // audio sources
   input  wire logic [1:0][AUD_W-1:0]        src_data,
   input  wire logic [1:0]                   src_valid,
   // audio sinks
   output var  logic [2:0][AUD_W-1:0]        sink_data,
   output var  logic [2:0]                   sink_valid,
   // interrupt
   output var  logic                         irq
);
   import acx_pkg::*;

   localparam int SYNC_W = 21;

   logic [SYNC_W-1:0]  sense_meta_reg;
   logic [SYNC_W-1:0]  sense_reg;
   logic [4:0]         pres_d_reg;
   logic [14:0]        port_d_reg;
   logic [2:0]         route_reg;
   logic [2:0]         route_next;
   logic [2:0]         auto_en_reg;
   acx_mode_type       mode_reg [3];
   logic [5:0]         rank_reg;
   logic [4:0]         mute_reg;
   logic [4:0]         lock_reg;
   logic [4:0]         irq_stat_reg;
   logic [4:0]         irq_mask_reg;
   logic [4:0]         irq_event;
   logic               refused;
   logic [4:0]         s_pres;
   logic [4:0]         s_known;
   logic [4:0]         s_linked;
   logic [2:0]         s_vsel;
   logic [2:0]         s_vaud;
   logic [1:0]         act;
   logic [1:0]         rise;
   logic               wr_fire;
   logic               setup;
   logic               sw_fire;
   logic               sw_in;
   logic [1:0]         sw_out;
   logic               sw_all;

   // ascii hex digit of a nibble
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      if (n < 4'hA)
         hex_char = `ACX_CH_0 + {4'h0, n};
      else
         hex_char = `ACX_CH_A_LESS10 + {4'h0, n};
   endfunction

   // two-byte status value of one port
   function automatic logic [15:0] port_status(input logic pres,
                                               input logic known,
                                               input logic linked);
      logic [1:0] sig;
      logic [1:0] con;
      sig = pres ? 2'b11 : 2'b10;
      con = !known ? 2'b00 : (linked ? 2'b11 : 2'b10);
      port_status = {12'h000, sig, con};
   endfunction

   // mute/lock letter
   function automatic logic [7:0] state_letter(input logic mute,
                                               input logic lock);
      unique case ({mute, lock})
         2'b00:   state_letter = `ACX_CH_T;
         2'b01:   state_letter = `ACX_CH_L;
         2'b10:   state_letter = `ACX_CH_M;
         2'b11:   state_letter = `ACX_CH_U;
      endcase
   endfunction

   // two-letter auto pick code of one output
   function automatic logic [15:0] auto_code(input logic en,
                                             input acx_mode_type m);
      logic [7:0] ml;
      unique case (m)
         ACX_MODE_FIRST:    ml = `ACX_CH_F;
         ACX_MODE_PRIORITY: ml = `ACX_CH_P;
         ACX_MODE_LAST:     ml = `ACX_CH_L;
         ACX_MODE_STATIC:   ml = `ACX_CH_S;
      endcase
      auto_code = {en ? `ACX_CH_E : `ACX_CH_D, ml};
   endfunction

   // best ranked active input; ties go to input 0
   function automatic logic best_input(input logic [1:0] a,
                                       input logic [1:0] rk);
      if (a == 2'b11)
         best_input = (rk[1] < rk[0]);
      else
         best_input = !a[0];
   endfunction

   // sense pins cross into clk_sys
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sense_meta_reg <= '0;
         sense_reg      <= '0;
      end
      else
      begin
         sense_meta_reg <= {video_has_audio, video_sel, port_linked,
                            port_link_known, port_present};
         sense_reg      <= sense_meta_reg;
      end
   end

   assign s_pres   = sense_reg[4:0];
   assign s_known  = sense_reg[9:5];
   assign s_linked = sense_reg[14:10];
   assign s_vsel   = sense_reg[17:15];
   assign s_vaud   = sense_reg[20:18];
   assign act      = s_pres[1:0];
   assign rise     = s_pres[1:0] & ~pres_d_reg[1:0];

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pres_d_reg <= '0;
         port_d_reg <= '0;
      end
      else
      begin
         pres_d_reg <= s_pres;
         port_d_reg <= sense_reg[14:0];
      end
   end

   // apb decode
   assign setup   = psel && !penable;
   assign wr_fire = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign sw_fire = wr_fire && (paddr == `ACX_OFS_SWITCH);
   assign sw_in   = pwdata[`ACX_SW_IN_BIT];
   assign sw_out  = pwdata[`ACX_SW_OUT_LSB +: 2];
   assign sw_all  = pwdata[`ACX_SW_ALL_BIT];

   // route selection: auto pick first, a manual write overrides it
   always_comb
   begin
      logic cand;
      logic cur;
      logic manual;
      cand       = 1'b0;
      cur        = 1'b0;
      manual     = 1'b0;
      route_next = route_reg;
      refused    = sw_fire && !sw_all && (sw_out == 2'd3);
      for (int o = 0; o < 3; o++)
      begin
         cur    = route_reg[o];
         cand   = cur;
         manual = sw_fire && (sw_all || (sw_out == 2'(o)));
         if (auto_en_reg[o])
         begin
            unique case (mode_reg[o])
               ACX_MODE_FIRST:
                  if (!act[cur] && (act != 2'b00))
                     cand = (rise != 2'b00) ? !rise[0] : !act[0];
               ACX_MODE_PRIORITY:
                  if (act != 2'b00)
                     cand = best_input(act, rank_reg[2*o +: 2]);
               ACX_MODE_LAST:
                  if (rise != 2'b00)
                     cand = !rise[0];
               ACX_MODE_STATIC:
                  if (s_vaud[o])
                     cand = s_vsel[o];
            endcase
         end
         if (manual)
            cand = sw_in;
         if (cand != cur)
         begin
            if (lock_reg[2+o] || lock_reg[cand] || lock_reg[cur])
               refused = refused || manual;
            else
               route_next[o] = cand;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         route_reg <= '0;
      else
         route_reg <= route_next;
   end

   // auto pick settings; only selected outputs update
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         auto_en_reg <= '0;
         for (int o = 0; o < 3; o++)
            mode_reg[o] <= ACX_MODE_FIRST;
      end
      else if (wr_fire && (paddr == `ACX_OFS_AUTO))
      begin
         for (int o = 0; o < 3; o++)
         begin
            if (pwdata[`ACX_AUTO_SEL_LSB + o])
            begin
               auto_en_reg[o] <= pwdata[4*o];
               mode_reg[o]    <= acx_mode_type'(pwdata[4*o+1 +: 2]);
            end
         end
      end
   end

   // ranks, mute and lock
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rank_reg <= `ACX_RST_RANK;
         mute_reg <= `ACX_RST_HOLD;
         lock_reg <= `ACX_RST_HOLD;
      end
      else if (wr_fire && (paddr == `ACX_OFS_RANK))
         rank_reg <= pwdata[5:0];
      else if (wr_fire && (paddr == `ACX_OFS_HOLD))
      begin
         mute_reg <= pwdata[4:0];
         lock_reg <= pwdata[`ACX_HOLD_LOCK_LSB +: 5];
      end
   end

   // audio path; muted source or sink sends silence
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sink_data  <= '0;
         sink_valid <= '0;
      end
      else
      begin
         for (int o = 0; o < 3; o++)
         begin
            sink_valid[o] <= src_valid[route_reg[o]];
            if (mute_reg[2+o] || mute_reg[route_reg[o]])
               sink_data[o] <= '0;
            else
               sink_data[o] <= src_data[route_reg[o]];
         end
      end
   end

   // interrupt status, set wins over write-one-to-clear
   always_comb
   begin
      irq_event                    = '0;
      irq_event[2:0]               = route_next ^ route_reg;
      irq_event[`ACX_IRQ_REFUSED]  = refused;
      irq_event[`ACX_IRQ_PORTCHG]  = (sense_reg[14:0] != port_d_reg);
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end
      else
      begin
         if (wr_fire && (paddr == `ACX_OFS_IRQ_STAT))
            irq_stat_reg <= (irq_stat_reg & ~pwdata[4:0]) | irq_event;
         else
            irq_stat_reg <= irq_stat_reg | irq_event;
         if (wr_fire && (paddr == `ACX_OFS_IRQ_MASK))
            irq_mask_reg <= pwdata[4:0];
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // read data captured in the setup cycle, zero wait states
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         logic [2:0]  p;
         logic [15:0] st;
         p       = 3'(paddr[5:3]);
         st      = port_status(s_pres[p], s_known[p], s_linked[p]);
         prdata  <= '0;
         pslverr <= 1'b0;
         unique case (paddr)
            `ACX_OFS_SWITCH:   prdata <= '0;
            `ACX_OFS_ROUTES:   prdata <= {29'h0, route_reg};
            `ACX_OFS_AUTO:
               for (int o = 0; o < 3; o++)
               begin
                  prdata[4*o]      <= auto_en_reg[o];
                  prdata[4*o+1+:2] <= mode_reg[o];
               end
            `ACX_OFS_RANK:     prdata <= {26'h0, rank_reg};
            `ACX_OFS_HOLD:     prdata <= {19'h0, lock_reg, 3'h0, mute_reg};
            `ACX_OFS_IRQ_STAT: prdata <= {27'h0, irq_stat_reg};
            `ACX_OFS_IRQ_MASK: prdata <= {27'h0, irq_mask_reg};
            `ACX_OFS_AUTO_TXT0:
               prdata <= {auto_code(auto_en_reg[1], mode_reg[1]),
                          auto_code(auto_en_reg[0], mode_reg[0])};
            `ACX_OFS_AUTO_TXT1:
               prdata <= {16'h0, auto_code(auto_en_reg[2], mode_reg[2])};
            default:
               if ((paddr >= `ACX_OFS_CODE_BASE)
                   && (paddr <= `ACX_OFS_CODE_LAST)
                   && (paddr[1:0] == 2'b00))
               begin
                  // ports laid out in order, so outputs follow in order
                  if (!paddr[2])
                     prdata <= {state_letter(mute_reg[p], lock_reg[p]),
                                hex_char(st[15:12]), hex_char(st[11:8]),
                                hex_char(st[7:4])};
                  else
                     prdata <= {24'h0, hex_char(st[3:0])};
               end
               else
                  pslverr <= 1'b1;
         endcase
      end
   end

endmodule : acx_crosspoint

`default_nettype wire

// File: acx_crosspoint_sva.sv
// checker for the audio crosspoint register reads and audio valids
// bound to acx_crosspoint; sees only its ports
`default_nettype none
`include "acx_map.svh"
module acx_crosspoint_sva
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        resetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   // audio
   input wire logic [1:0]  src_valid,
   input wire logic [2:0]  sink_valid
);
   logic rd_setup;
   logic code_lo;
   logic code_hi;
   assign rd_setup = psel && !penable && !pwrite;
   assign code_lo = rd_setup && paddr >= 8'h40 && paddr <= 8'h60;
   assign code_hi = code_lo || (rd_setup && paddr == 8'h64);
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   chk_code_zeros: assert property (code_lo && paddr[2:0] == 3'h0 |=>
      prdata[23:0] == 24'h30_3030) else $error("code chars not zero");
   chk_code_letter: assert property (code_lo && paddr[2:0] == 3'h0 |=>
      prdata[31:24] inside {8'h54, 8'h4C, 8'h4D, 8'h55})
      else $error("bad state letter");
   chk_code_last: assert property (code_hi && paddr[2:0] == 3'h4 |=>
      prdata inside {32'h38, 32'h41, 32'h42, 32'h43, 32'h45, 32'h46})
      else $error("bad status char");
   chk_auto_enable: assert property (rd_setup &&
      paddr == `ACX_OFS_AUTO_TXT0 |=> prdata[15:8] inside {8'h45, 8'h44}
      && prdata[31:24] inside {8'h45, 8'h44}) else $error("bad enable");
   chk_auto_mode: assert property (rd_setup &&
      paddr == `ACX_OFS_AUTO_TXT0 |=> prdata[7:0] inside
      {8'h46, 8'h50, 8'h4C, 8'h53}) else $error("bad mode letter");
   chk_routes_width: assert property (rd_setup &&
      paddr == `ACX_OFS_ROUTES |=> prdata[31:3] == '0)
      else $error("route bits out of range");
   chk_valid_idle: assert property (src_valid == 2'b00 |=>
      sink_valid == 3'b000) else $error("sink valid without source");
   chk_valid_full: assert property (src_valid == 2'b11 |=>
      sink_valid == 3'b111) else $error("sink valid lost");
   cover property (rd_setup && paddr == `ACX_OFS_ROUTES);
   cover property (psel && penable && pwrite && paddr == `ACX_OFS_SWITCH);
   cover property (src_valid == 2'b00);
endmodule // acx_crosspoint_sva

bind acx_crosspoint acx_crosspoint_sva chk_u
(
   .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .src_valid(src_valid), .sink_valid(sink_valid)
);
`default_nettype wire

// File: acx_audio_env.sv
// audio sources feeding the crosspoint inputs
// runs on clk_sys; the bench may drop the valid of both sources, samples keep counting
`default_nettype none
module acx_audio_env
#(
   parameter int AUD_W = 24
)
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // control
   input  wire logic                  quiet,
   // sources
   output var  logic [1:0][AUD_W-1:0] src_data,
   output var  logic [1:0]            src_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_reg;
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + 16'h0001;
   end
   // samples differ per input and per cycle so a wrong route shows
   assign src_data = {AUD_W'({8'h22, cnt_reg}), AUD_W'({8'h11, cnt_reg})};
   assign src_valid = quiet ? 2'b00 : 2'b11;
endmodule // acx_audio_env
`default_nettype wire

// File: tb_audio_crosspoint_autoselect.sv
// bench for the audio crosspoint: apb tasks, scenarios, verdict
// uses acx_audio_env as sources; the checker binds itself
`default_nettype none
`include "acx_map.svh"
module tb_audio_crosspoint_autoselect;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_sys = 1'b0;
   logic             resetn = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic             quiet = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0000_0000;
   logic [4:0]       pres = 5'b00100;
   logic [4:0]       known = 5'b11111;
   logic [4:0]       linked = 5'b10100;
   logic [2:0]       vsel = 3'b000;
   logic [2:0]       vaud = 3'b000;
   logic             pready, pslverr, irq, er;
   logic [31:0]      prdata, rd;
   logic [1:0]       src_valid;
   logic [2:0]       sink_valid;
   logic [1:0][23:0] src_data;
   logic [2:0][23:0] sink_data;
   int               err_count = 0;
   int               num_checks = 0;
   int               cyc = 0;

   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end

   acx_audio_env env_u (.clk_sys(clk_sys), .resetn(resetn), .quiet(quiet),
      .src_data(src_data), .src_valid(src_valid));
   acx_crosspoint #(.AUD_W(24)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_present(pres), .port_link_known(known), .port_linked(linked),
      .video_sel(vsel), .video_has_audio(vaud), .src_data(src_data),
      .src_valid(src_valid), .sink_data(sink_data),
      .sink_valid(sink_valid), .irq(irq));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, e);
   endtask

   task automatic aud_chk(input int o, input int i, input logic mute);
      logic [23:0] s;
      @(negedge clk_sys);
      s = mute ? 24'h0 : src_data[i];
      @(negedge clk_sys);
      check({8'h0, sink_data[o]}, {8'h0, s});
   endtask

   task automatic t_reset();
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0000);
      rd_chk(`ACX_OFS_RANK, 32'h0000_002A);
      rd_chk(`ACX_OFS_HOLD, 32'h0000_0000);
      rd_chk(`ACX_OFS_AUTO, 32'h0000_0000);
      rd_chk(`ACX_OFS_AUTO_TXT0, 32'h4446_4446);
      apb(1'b0, 8'h30, 32'h0000_0000);
      check({31'h0, er}, 32'h1);
      apb(1'b0, 8'h06, 32'h0000_0000);
      check({31'h0, er}, 32'h1);
   endtask

   task automatic t_codes();
      logic [2:0] cfg [4];
      logic [7:0] ch [4];
      cfg = '{3'b010, 3'b011, 3'b111, 3'b100};
      ch = '{8'h41, 8'h42, 8'h46, 8'h43};
      rd_chk(8'h54, 32'h0000_0046);
      rd_chk(8'h5C, 32'h0000_0041);
      rd_chk(8'h64, 32'h0000_0042);
      for (int i = 0; i < 4; i++)
      begin
         pres[0] <= cfg[i][2];
         known[0] <= cfg[i][1];
         linked[0] <= cfg[i][0];
         repeat (4) @(posedge clk_sys);
         rd_chk(8'h44, {24'h0, ch[i]});
      end
      rd_chk(8'h40, 32'h5430_3030);
   endtask

   task automatic t_manual();
      wr(`ACX_OFS_SWITCH, 32'h0000_0101);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0007);
      wr(`ACX_OFS_SWITCH, 32'h0000_0002);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0005);
      wr(`ACX_OFS_SWITCH, 32'h0000_0007);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0005);
      aud_chk(0, 1, 1'b0);
      aud_chk(1, 0, 1'b0);
      wr(`ACX_OFS_HOLD, 32'h0000_0002);
      aud_chk(0, 1, 1'b1);
      aud_chk(1, 0, 1'b0);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0005);
      quiet <= 1'b1;
      repeat (3) @(posedge clk_sys);
      quiet <= 1'b0;
   endtask

   task automatic t_lock();
      logic [7:0] lt [4];
      lt = '{8'h54, 8'h4D, 8'h4C, 8'h55};
      for (int k = 0; k < 4; k++)
      begin
         wr(`ACX_OFS_HOLD, {20'h0, k[1], 7'h0, k[0], 3'h0});
         rd_chk(8'h58, {lt[k], 24'h30_3030});
      end
      @(negedge clk_sys);
      check({31'h0, irq}, 32'h0);
      wr(`ACX_OFS_IRQ_MASK, 32'h0000_0008);
      // drop the refusal left over from the manual test first
      wr(`ACX_OFS_IRQ_STAT, 32'h0000_0008);
      @(negedge clk_sys);
      check({31'h0, irq}, 32'h0);
      wr(`ACX_OFS_SWITCH, 32'h0000_0003);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0005);
      @(negedge clk_sys);
      check({31'h0, irq}, 32'h1);
      wr(`ACX_OFS_IRQ_STAT, 32'h0000_0008);
      @(negedge clk_sys);
      check({31'h0, irq}, 32'h0);
      wr(`ACX_OFS_HOLD, 32'h0000_0000);
   endtask

   task automatic t_auto();
      pres[1:0] <= 2'b11;
      linked[1:0] <= 2'b11;
      wr(`ACX_OFS_AUTO, 32'h0001_0003);
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_AUTO_TXT0, 32'h4446_4550);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0004);
      wr(`ACX_OFS_RANK, 32'h0000_0029);
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0005);
      wr(`ACX_OFS_RANK, 32'h0000_002B);
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0004);
      wr(`ACX_OFS_AUTO, 32'h0001_0002);
      wr(`ACX_OFS_RANK, 32'h0000_0029);
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_AUTO_TXT0, 32'h4446_4450);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0004);
      vaud[2] <= 1'b1;
      wr(`ACX_OFS_AUTO, 32'h0004_0700);
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0000);
      vsel[2] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0004);
      rd_chk(`ACX_OFS_AUTO, 32'h0000_0702);
   endtask

   task automatic t_modes();
      wr(`ACX_OFS_AUTO, 32'h0002_0010);
      pres[0] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0006);
      pres[0] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0006);
      wr(`ACX_OFS_AUTO, 32'h0002_0050);
      pres[0] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0006);
      pres[0] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_chk(`ACX_OFS_ROUTES, 32'h0000_0004);
      rd_chk(`ACX_OFS_AUTO_TXT0, 32'h454C_4450);
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_codes();
      t_manual();
      t_lock();
      t_auto();
      t_modes();
      report_and_stop();
   end
endmodule // tb_audio_crosspoint_autoselect
`default_nettype wire
